/* File: verilog/acs_map.svh */
// Constants for the acceleration sensor SPI slave: fields, codes, resets
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH
`define ACS_FRAME_BITS     16
`define ACS_CMD_B15        15
`define ACS_CMD_B14        14
`define ACS_CMD_ACC        13
`define ACS_ADDR_HI        12
`define ACS_ADDR_LO        8
`define ACS_RSP_AXIS       13
`define ACS_RSP_PAR        12
`define ACS_RSP_S1         11
`define ACS_RSP_S0         10
`define ACS_ST_ACCEL       2'h1
`define ACS_ST_SELFTEST    2'h2
`define ACS_ST_ERROR       2'h3
`define ACS_FLG_ND         4
`define ACS_FLG_HE         3
`define ACS_FLG_CNC        2
`define ACS_CTL_ADDR       5'h0_0
`define ACS_STAT_ADDR      5'h1_0
`define ACS_CTL_CE         4
`define ACS_CTL_HIGHPASS_BYPASS_BIT       3
`define ACS_CTL_ST1        1
`define ACS_CTL_ST0        0
`define ACS_CTL_RDMASK     8'h0_B
`define ACS_CTL_RESET      8'h0_0
`define ACS_STAT_OSCF      6
`define ACS_STAT_INIT      5
`define ACS_STAT_DEVRES    0
`define ACS_REQ_ERR_FRAME  16'h0_0_0_0
`define ACS_SPI_ERR_FRAME  16'h0_0_0_0
`define ACS_RSP_RESET      16'h0_0_0_0
`endif

/* File: verilog/acs_pkg.sv */
// Types for the acceleration sensor SPI slave
`default_nettype none
package acs_pkg;
  typedef enum logic [3:0] {
    ACS_OP_ACCEL = 4'b0001,
    ACS_OP_WRITE = 4'b0010,
    ACS_OP_READ  = 4'b0100,
    ACS_OP_TEST  = 4'b1000
  } acs_op_t;
endpackage
`default_nettype wire

/* File: verilog/acs_link.sv */
// Link-side shifter on the serial clock: frame capture and response shift
`default_nettype none
`include "acs_map.svh"
module acs_link (
  input  wire logic        sclk_in,    // Serial clock from master
  input  wire logic        cs_n_in,    // Chip select, active low
  input  wire logic        din_in,     // Serial data in
  input  wire logic [15:0] rsp_in,     // Response word, stable while selected
  input  wire logic        oscf_in,    // Oscillator fault level (synced)
  output logic             dout_out,   // Serial data out
  output logic [15:0]      cmd_out,    // Shifted-in word
  output logic [4:0]       edges_out   // Rising edge count, saturating
);
  logic [15:0] sh_q;
  logic [4:0]  cnt_q;
  logic [15:0] tx_q;
  logic [4:0]  edges_q;

  // Async clear by chip select: the link clock stops outside frames
  always_ff @(posedge sclk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      cnt_q <= 5'h0_0;
    end else if (cnt_q != 5'h1_F) begin
      cnt_q <= cnt_q + 5'h0_1;
    end
  end

  // Count kept at deselect; the counter itself is cleared by that edge
  always_ff @(posedge cs_n_in) begin
    edges_q <= cnt_q;
  end

  // Sample on rising edge, MSB first
  always_ff @(posedge sclk_in) begin
    if (!cs_n_in) begin
      sh_q <= {sh_q[14:0], din_in};
    end
  end

  // Change data on falling edge, MSB first; bit 15 presented at select
  always_ff @(negedge sclk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      tx_q <= 16'h0_0_0_0;
    end else if (cnt_q != 5'h0_0) begin
      tx_q <= {tx_q[14:0], 1'b0} | ((cnt_q == 5'h0_1) ? {rsp_in[14:0], 1'b0}
                                                      : 16'h0_0_0_0);
    end
  end

  // Oscillator fault forces the line high while selected
  always_comb begin
    if (oscf_in) begin
      dout_out = 1'b1;
    end else if (cnt_q == 5'h0_0) begin
      dout_out = rsp_in[15];
    end else begin
      dout_out = tx_q[15];
    end
  end

  assign cmd_out   = sh_q;
  assign edges_out = edges_q;
endmodule // acs_link
`default_nettype wire

/* File: verilog/acs_spi_slave.sv */
// SPI command interpreter for the dual-axis acceleration sensor
`default_nettype none
`include "acs_map.svh"
module acs_spi_slave #(
  parameter int DATA_W = 10                 // Acceleration value width
) (
  input  wire logic              clk_in,          // System clock 10 MHz
  input  wire logic              rstn_in,         // Sync reset, active low
  input  wire logic              sclk_in,         // SPI serial clock
  input  wire logic              cs_n_in,         // SPI chip select, low
  input  wire logic              din_in,          // SPI serial data in
  output logic                   dout_out,        // SPI serial data out
  input  wire logic [DATA_W-1:0] accel_x_in,      // X sample, signed
  input  wire logic [DATA_W-1:0] accel_y_in,      // Y sample, signed
  input  wire logic              init_ph1_in,     // Init phase one active
  input  wire logic              init_ph2_in,     // Init phase two active
  input  wire logic              osc_fault_in,    // Oscillator fault
  input  wire logic              temp_fault_in,   // Over-temperature
  input  wire logic              offset_fault_in, // Offset error
  input  wire logic              parity_fault_in, // Internal parity error
  input  wire logic [7:0]        reg_rdata_in,    // Other register data
  output logic [4:0]             reg_addr_out,    // Last read address
  output logic [7:0]             device_control_reg_out, // Control reg
  output logic                   clear_error_out  // Clear-error pulse
);
  // Synchronisers for pin-level inputs into clk_in
  logic [1:0] cs_sync_q;
  logic [1:0] sclk_sync_q;
  logic [1:0] osc_lsync_q;
  logic       cs_prev_q;
  logic       spi_err_q;
  logic       frame_pend_q;
  logic       frame_tog_q;
  logic [1:0] ftog_sync_q;
  logic       ftog_seen_q;
  logic [15:0] cmd_hold_q;
  logic [15:0] rsp_q;
  logic [15:0] rsp_d;
  logic [7:0]  ctl_q;
  logic        devres_q;
  logic        nd_pend_q;
  logic        clr_q;
  logic [4:0]  raddr_q;
  logic        oscf_link_q;
  logic [15:0] link_cmd;
  logic [4:0]  link_edges;
  logic [7:0]  stat;
  logic        cs_rise;
  logic        cs_fall;
  logic        new_frame;
  acs_pkg::acs_op_t op;

  // Odd parity over the whole frame, used where parity is carried
  function automatic logic [15:0] acs_with_parity(input logic [15:0] f);
    logic [15:0] g;
    g = f;
    g[`ACS_RSP_PAR] = ~(^{f[15:13], f[11:0]});
    return g;
  endfunction

  // Link-side capture; response word is held in clk_in domain and only
  // changes while deselected, so the link reads it quasi-statically
  acs_link u_link (
    .sclk_in   (sclk_in),
    .cs_n_in   (cs_n_in | init_ph1_in),   // Silent in phase one
    .din_in    (din_in),
    .rsp_in    (rsp_q),
    .oscf_in   (oscf_link_q),
    .dout_out  (dout_out),
    .cmd_out   (link_cmd),
    .edges_out (link_edges)
  );

  // Two-flop synchronisers; only the second stage is used
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      cs_sync_q   <= 2'h3;
      sclk_sync_q <= 2'h0;
      osc_lsync_q <= 2'h0;
    end else begin
      cs_sync_q   <= {cs_sync_q[0], cs_n_in};
      sclk_sync_q <= {sclk_sync_q[0], sclk_in};
      osc_lsync_q <= {osc_lsync_q[0], osc_fault_in};
    end
  end

  // Fault level for the link, registered every cycle, so it follows the fault during frames too
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      oscf_link_q <= 1'b0;
    end else begin
      oscf_link_q <= osc_lsync_q[1];
    end
  end

  assign cs_fall = cs_prev_q & ~cs_sync_q[1];
  assign cs_rise = ~cs_prev_q & cs_sync_q[1];

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      cs_prev_q <= 1'b1;
    end else begin
      cs_prev_q <= cs_sync_q[1];
    end
  end

  // Clock level at select edges; sampled via synchroniser, so a master
  // must keep the clock settled a few system clocks around select
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      spi_err_q <= 1'b0;
    end else if (cs_fall) begin
      spi_err_q <= sclk_sync_q[1];
    end else if (cs_rise && sclk_sync_q[1]) begin
      spi_err_q <= 1'b1;
    end
  end

  // Deselect seen here: wait for link words to settle, then decode
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      frame_pend_q <= 1'b0;
      cmd_hold_q   <= 16'h0_0_0_0;
    end else if (cs_rise && !init_ph1_in) begin
      frame_pend_q <= 1'b1;
      cmd_hold_q   <= {11'h0_0_0, link_edges};
    end else begin
      frame_pend_q <= 1'b0;
    end
  end

  // Event toggle kept local; no second-domain writer exists for it
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      frame_tog_q <= 1'b0;
      ftog_sync_q <= 2'h0;
      ftog_seen_q <= 1'b0;
    end else begin
      frame_tog_q <= frame_tog_q ^ frame_pend_q;
      ftog_sync_q <= {ftog_sync_q[0], frame_tog_q};
      ftog_seen_q <= ftog_sync_q[1];
    end
  end

  assign new_frame = ftog_sync_q[1] ^ ftog_seen_q;

  // Device status register image
  always_comb begin
    stat = 8'h0_0;
    stat[7] = parity_fault_in;
    stat[`ACS_STAT_OSCF] = osc_lsync_q[1];
    stat[`ACS_STAT_INIT] = init_ph1_in | init_ph2_in;
    stat[4] = temp_fault_in;
    stat[3] = ctl_q[`ACS_CTL_HIGHPASS_BYPASS_BIT];
    stat[2] = offset_fault_in;
    stat[1] = offset_fault_in;
    stat[`ACS_STAT_DEVRES] = devres_q;
  end

  // Operation decode from the captured word
  always_comb begin
    if (link_cmd[`ACS_CMD_ACC]) begin
      op = acs_pkg::ACS_OP_ACCEL;
    end else if (link_cmd[`ACS_CMD_B15] && link_cmd[`ACS_CMD_B14]) begin
      op = acs_pkg::ACS_OP_TEST;
    end else if (link_cmd[`ACS_CMD_B15]) begin
      op = acs_pkg::ACS_OP_READ;
    end else begin
      op = acs_pkg::ACS_OP_WRITE;
    end
  end

  // Next response word, highest priority first
  always_comb begin
    rsp_d = rsp_q;
    if (cmd_hold_q[4:0] != 5'h1_0 || spi_err_q) begin
      rsp_d = `ACS_SPI_ERR_FRAME;
    end else begin
      unique case (op)
        acs_pkg::ACS_OP_ACCEL: begin
          rsp_d = 16'h0_0_0_0;
          rsp_d[`ACS_RSP_AXIS] = link_cmd[`ACS_CMD_B14];
          if (link_cmd[`ACS_CMD_B15] || nd_pend_q || init_ph2_in ||
              temp_fault_in || offset_fault_in || parity_fault_in) begin
            rsp_d[11:10] = `ACS_ST_ERROR;
            rsp_d[`ACS_FLG_ND]  = nd_pend_q | init_ph2_in;
            rsp_d[`ACS_FLG_HE]  = temp_fault_in | offset_fault_in |
                                  parity_fault_in;
            rsp_d[`ACS_FLG_CNC] = link_cmd[`ACS_CMD_B15];
          end else begin
            rsp_d[11:10] = ctl_q[`ACS_CTL_ST0] ? `ACS_ST_SELFTEST
                                               : `ACS_ST_ACCEL;
            rsp_d[9:0] = link_cmd[`ACS_CMD_B14] ? accel_y_in[9:0]
                                                : accel_x_in[9:0];
          end
          rsp_d = acs_with_parity(rsp_d);
        end
        acs_pkg::ACS_OP_WRITE: begin
          if (!link_cmd[`ACS_CMD_B14] ||
              link_cmd[12:8] != `ACS_CTL_ADDR) begin
            rsp_d = `ACS_REQ_ERR_FRAME;
          end else begin
            rsp_d = {link_cmd[15:8], link_cmd[7:0] & `ACS_CTL_RDMASK};
          end
        end
        acs_pkg::ACS_OP_READ: begin
          rsp_d = {link_cmd[15:8],
                   (link_cmd[12:8] == `ACS_CTL_ADDR) ?
                     (ctl_q & `ACS_CTL_RDMASK) :
                   (link_cmd[12:8] == `ACS_STAT_ADDR) ? stat
                                                      : reg_rdata_in};
        end
        acs_pkg::ACS_OP_TEST: begin
          rsp_d = {link_cmd[15:8], stat};
        end
      endcase
    end
  end

  // Pending response: one slot, replaced at each decoded frame
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      rsp_q <= `ACS_REQ_ERR_FRAME;
    end else if (new_frame) begin
      rsp_q <= rsp_d;
    end
  end

  // Control register writes and clear-error pulse
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      ctl_q <= `ACS_CTL_RESET;
      clr_q <= 1'b0;
    end else begin
      clr_q <= 1'b0;
      if (new_frame && !spi_err_q && cmd_hold_q[4:0] == 5'h1_0 &&
          op == acs_pkg::ACS_OP_WRITE && link_cmd[`ACS_CMD_B14] &&
          link_cmd[12:8] == `ACS_CTL_ADDR) begin
        ctl_q <= link_cmd[7:0] & `ACS_CTL_RDMASK;
        clr_q <= link_cmd[`ACS_CTL_CE];
      end
    end
  end

  // Reset flag: set wins over a clear in the same cycle
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      devres_q <= 1'b1;
    end else if (clr_q && !init_ph1_in && !init_ph2_in) begin
      devres_q <= 1'b0;
    end
  end

  // First good acceleration request after init also gets no-data
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      nd_pend_q <= 1'b1;
    end else if (new_frame && !spi_err_q && cmd_hold_q[4:0] == 5'h1_0 &&
                 op == acs_pkg::ACS_OP_ACCEL && !init_ph2_in) begin
      nd_pend_q <= 1'b0;
    end
  end

  // Last read address for the external register file
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      raddr_q <= 5'h0_0;
    end else if (new_frame && op == acs_pkg::ACS_OP_READ) begin
      raddr_q <= link_cmd[12:8];
    end
  end

  assign reg_addr_out           = raddr_q;
  assign device_control_reg_out = ctl_q;
  assign clear_error_out        = clr_q;
endmodule // acs_spi_slave
`default_nettype wire

/* File: tb/acs_spi_slave_checker.sv */
// Port-level assertions for the acceleration sensor SPI slave
`default_nettype none
`include "acs_map.svh"
module acs_spi_slave_checker (
  input wire logic       clk_in,                 // System clock
  input wire logic       rstn_in,                // Sync reset, low
  input wire logic       cs_n_in,                // Chip select, low
  input wire logic       dout_out,               // Serial data out
  input wire logic       osc_fault_in,           // Oscillator fault
  input wire logic [4:0] reg_addr_out,           // Last read address
  input wire logic [7:0] device_control_reg_out, // Control register
  input wire logic       clear_error_out         // Clear-error pulse
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  // Start of a frame, and decoded state left alone while it shifts
  sequence sel_start;
    $fell(cs_n_in);
  endsequence
  sequence quiet;
    $stable(device_control_reg_out) && $stable(reg_addr_out)
      && !clear_error_out;
  endsequence
  a_ctl_reset_zero: assert property (
    $rose(rstn_in) |-> device_control_reg_out == 8'h00 && !clear_error_out)
    else $error("control register not clear after reset");
  a_ctl_bits_kept: assert property (
    (device_control_reg_out & ~`ACS_CTL_RDMASK) == 8'h00)
    else $error("control register holds unkept bits");
  a_clr_one_pulse: assert property (
    clear_error_out |=> !clear_error_out)
    else $error("clear-error pulse longer than one cycle");
  a_ctl_after_frame: assert property (
    $changed(device_control_reg_out) |-> cs_n_in && $past(cs_n_in, 3))
    else $error("control register changed inside a frame");
  a_addr_after_frame: assert property (
    $changed(reg_addr_out) |-> cs_n_in && $past(cs_n_in, 3))
    else $error("read address changed inside a frame");
  a_clr_when_idle: assert property (
    clear_error_out |-> cs_n_in && $past(cs_n_in, 2))
    else $error("clear-error pulse inside a frame");
  a_frame_quiet: assert property (
    sel_start |-> quiet[*4])
    else $error("decoded state moved while selected");
  a_osc_dout_high: assert property (
    !cs_n_in && osc_fault_in && $past(osc_fault_in, 4) |-> dout_out)
    else $error("serial out low under oscillator fault");
endmodule // acs_spi_slave_checker
bind acs_spi_slave acs_spi_slave_checker u_chk (
  .clk_in(clk_in), .rstn_in(rstn_in), .cs_n_in(cs_n_in),
  .dout_out(dout_out), .osc_fault_in(osc_fault_in),
  .reg_addr_out(reg_addr_out),
  .device_control_reg_out(device_control_reg_out),
  .clear_error_out(clear_error_out));
`default_nettype wire

/* File: tb/acs_master_model.sv */
// Behavioural mode-zero SPI master standing at the sensor's link
`default_nettype none
module acs_master_model (
  output logic      sclk_out, // Serial clock, idle low
  output logic      cs_n_out, // Chip select, active low
  output logic      din_out,  // Serial data to slave
  input  wire logic dout_in   // Serial data from slave
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle: deselected, clock still
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    din_out  = 1'b0;
  end
  // One frame at 30 ns per bit; wrong counts or a high end on request
  task automatic xfer(input logic [15:0] cmd, input int edges,
                      input bit hi_end, output logic [15:0] rsp);
    int i;
    rsp = 16'h0000;
    cs_n_out = 1'b0;
    for (i = 0; i < edges; i++) begin
      din_out = cmd[15 - (i % 16)]; // MSB first, set while low
      #15 sclk_out = 1'b1;
      rsp = {rsp[14:0], dout_in}; // Sampled on the rise
      #15 sclk_out = hi_end && (i == edges - 1);
    end
    #15 cs_n_out = 1'b1;
    din_out = ~din_out; // Released line must not keep its last value
    if (hi_end) begin
      #500; // Clock stays high long enough for the slave to see it
    end
    #15 sclk_out = 1'b0;
  endtask
  // Traffic for some other slave while this one stays deselected
  task automatic noise();
    repeat (6) begin
      din_out = ~din_out;
      #15 sclk_out = ~sclk_out;
    end
    #15;
  endtask
endmodule // acs_master_model
`default_nettype wire

/* File: tb/acs_spi_slave_tb.sv */
// Self-checking bench for the acceleration sensor SPI slave
`default_nettype none
`include "acs_map.svh"
module acs_spi_slave_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [9:0] ND  = 10'h001 << `ACS_FLG_ND;
  localparam logic [9:0] HE  = 10'h001 << `ACS_FLG_HE;
  localparam logic [9:0] COMMAND_NOT_CORRECT_FLAG = 10'h001 << `ACS_FLG_CNC;
  logic        clk_in, rstn_in, sclk, cs_n, din, dout, clr, clr_seen;
  logic        ph1, ph2, osc, temp;
  logic [9:0]  ax, ay;
  logic [7:0]  rdata, ctl;
  logic [4:0]  raddr;
  logic [15:0] rsp;
  int          n_fail, check_count;
  acs_spi_slave DUT (
    .clk_in(clk_in), .rstn_in(rstn_in), .sclk_in(sclk), .cs_n_in(cs_n),
    .din_in(din), .dout_out(dout), .accel_x_in(ax), .accel_y_in(ay),
    .init_ph1_in(ph1), .init_ph2_in(ph2), .osc_fault_in(osc),
    .temp_fault_in(temp), .offset_fault_in(1'b0),
    .parity_fault_in(1'b0), .reg_rdata_in(rdata),
    .reg_addr_out(raddr), .device_control_reg_out(ctl),
    .clear_error_out(clr));
  acs_master_model mst (
    .sclk_out(sclk), .cs_n_out(cs_n), .din_out(din), .dout_in(dout));
  // 10 MHz system clock
  always #50 clk_in = ~clk_in;
  // Remember any clear-error pulse; it lasts one cycle only
  always @(posedge clk_in) if (clr === 1'b1) clr_seen <= 1'b1;
  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // A frame, then a gap longer than the decode delay
  task automatic frame(input logic [15:0] cmd, input int edges = 16,
                       input bit hi = 1'b0);
    mst.xfer(cmd, edges, hi, rsp);
    repeat (12) @(posedge clk_in);
  endtask
  // Response fields without parity, then odd parity over the word
  task automatic chk_acc(input string name, input logic axis,
                         input logic [1:0] st, input logic [9:0] d);
    check(name, {3'h0, rsp[13], rsp[11:0]}, {3'h0, axis, st, d});
    check("parity", {15'h0, ^rsp}, 16'h0001);
  endtask
  task automatic t_init();
    frame(16'h400B); // Ignored while phase one runs
    check("ctl ph1", {8'h0, ctl}, 16'h0000);
    @(posedge clk_in);
    ph1 <= 1'b0;
    ph2 <= 1'b1;
    frame(16'h2000);
    check("first", rsp, `ACS_REQ_ERR_FRAME);
    frame(16'h6000);
    chk_acc("nd x", 1'b0, `ACS_ST_ERROR, ND);
    frame(16'h4003);
    chk_acc("nd y", 1'b1, `ACS_ST_ERROR, ND);
    check("ctl ph2", {8'h0, ctl}, 16'h0003);
    @(posedge clk_in);
    ph2 <= 1'b0;
    frame(16'h2000);
    check("wr rsp", {8'h0, rsp[7:0]}, 16'h0003);
    frame(16'h2000);
    chk_acc("nd after", 1'b0, `ACS_ST_ERROR, ND);
    frame(16'h6000);
    chk_acc("selftest", 1'b0, `ACS_ST_SELFTEST, ax);
    $display("t_init done");
  endtask
  task automatic t_regs();
    frame(16'hC000);
    chk_acc("acc y", 1'b1, `ACS_ST_SELFTEST, ay);
    frame(16'h4010);
    check("devres", {15'h0, rsp[`ACS_STAT_DEVRES]}, 16'h0001);
    frame(16'hC000);
    check("clr", {15'h0, clr_seen}, 16'h0001);
    frame(16'h0000);
    check("devres 0", {15'h0, rsp[0]}, 16'h0000);
    frame(16'h4501);
    check("unused", rsp, `ACS_REQ_ERR_FRAME);
    @(posedge clk_in);
    rdata <= 8'hA5;
    frame(16'h85FF);
    check("bad wr", rsp, `ACS_REQ_ERR_FRAME);
    check("rd addr", {11'h0, raddr}, 16'h0005);
    frame(16'h8000);
    check("rd data", {8'h0, rsp[7:0]}, 16'h00A5);
    $display("t_regs done");
  endtask
  task automatic t_errs();
    @(posedge clk_in);
    temp <= 1'b1;
    frame(16'hA000);
    frame(16'h2000);
    chk_acc("cnc", 1'b0, `ACS_ST_ERROR, COMMAND_NOT_CORRECT_FLAG | HE);
    frame(16'h4008);
    chk_acc("he once", 1'b0, `ACS_ST_ERROR, HE);
    frame(16'hC000);
    check("wr fault", {8'h0, rsp[7:0]}, 16'h0008);
    @(posedge clk_in);
    temp <= 1'b0;
    frame(16'h4010);
    check("tf", {15'h0, rsp[4]}, 16'h0001);
    $display("t_errs done");
  endtask
  task automatic t_link();
    int k;
    for (k = 0; k < 3; k++) begin
      frame(16'h400B, (k == 2) ? 16 : 15 + 2 * k, k == 2);
      frame(16'h2000);
      check("spi err", rsp, `ACS_SPI_ERR_FRAME);
      check("ctl kept", {8'h0, ctl}, 16'h0000);
    end
    mst.noise();
    frame(16'h2000);
    chk_acc("after noise", 1'b0, `ACS_ST_ACCEL, ax);
    @(posedge clk_in);
    osc <= 1'b1;
    repeat (8) @(posedge clk_in);
    frame(16'hC000);
    check("osc", rsp, 16'hFFFF);
    $display("t_link done");
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (100000) @(posedge clk_in);
    n_fail++;
    $display("[FAIL] watchdog expected done seen hang");
    end_of_test();
  end
  // Reset for six cycles with init phase one, then the scenarios
  initial begin
    n_fail = 0;
    check_count = 0;
    clk_in = 1'b0;
    rstn_in = 1'b0;
    clr_seen = 1'b0;
    ph1 = 1'b1;
    ph2 = 1'b0;
    osc = 1'b0;
    temp = 1'b0;
    ax = 10'h155;
    ay = 10'h2A3;
    rdata = 8'h3C;
    repeat (6) @(posedge clk_in);
    rstn_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    t_init();
    t_regs();
    t_errs();
    t_link();
    end_of_test();
  end
endmodule // acs_spi_slave_tb
`default_nettype wire
